// File: design/clk_ctl_pins.sv
`timescale 1ns/1ps
`include "ctl_defs.svh"
// Contract
// [RL1] Primary gate low passes outputs, high disables
// [RL2] Primary gate governs all outputs after reset
// [RL3] Secondary gate idle until its subset configured
// [RL4] Each loop drives own lock-status output
// [RL5] Flag reference loss on missing crystal activity
// [RL6] Loop-select value steers every step request
// [RL7] Step down lowers selected loop by step
// [RL8] Step up raises selected loop by step
// [RL9] Rising step edge is one request, select sampled
module clk_ctl_pins (
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Control pins from the board
  input wire logic out_gate_primary_n,
  input wire logic out_gate_secondary_n,
  input wire logic loop_pick_bit0,
  input wire logic loop_pick_bit1,
  input wire logic freq_step_down,
  input wire logic freq_step_up,
  input wire logic ref_crystal_pins,
  // Lock indications from the four synthesis loops
  input wire logic [3:0] loop_locked,
  // Output clock enables, active high
  output logic [7:0] out_enable,
  // Status pins
  output logic loop_a_unlocked_n,
  output logic loop_b_unlocked_n,
  output logic loop_c_unlocked_n,
  output logic loop_d_unlocked_n,
  output logic ref_signal_missing_n,
  // Frequency offset of each loop
  output logic [31:0] loop_a_offset,
  output logic [31:0] loop_b_offset,
  output logic [31:0] loop_c_offset,
  output logic [31:0] loop_d_offset
);

  // Synchronised pins
  logic [`PIN_CNT-1:0] pins_s;
  logic pri_s;
  logic sec_s;
  logic [1:0] pick_s;
  logic [1:0] step_s;
  logic [1:0] step_pulse;
  logic ref_s;
  logic [3:0] lock_s;

  // Every pin is asynchronous to mclk, so all go through two flops
  pin_sync #(.W(`PIN_CNT)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({loop_locked, ref_crystal_pins, freq_step_up, freq_step_down,
        loop_pick_bit1, loop_pick_bit0, out_gate_secondary_n,
        out_gate_primary_n}),
    .q(pins_s)
  );

  assign pri_s = pins_s[0];
  assign sec_s = pins_s[1];
  assign pick_s = pins_s[3:2];
  assign step_s = pins_s[5:4];
  assign ref_s = pins_s[6];
  assign lock_s = pins_s[10:7];

  // Index 0 is step down, index 1 is step up
  genvar e;
  generate
    for (e = 0; e < 2; e++) begin : g_edge
      // [RL9] Edge makes request
      rise_pulse u_rise (
        .mclk(mclk),
        .reset_n(reset_n),
        .level(step_s[e]),
        .pulse(step_pulse[e])
      );
    end
  endgenerate

  // Registers
  logic [7:0] pri_mask_r, pri_mask_nxt;
  logic [7:0] sec_mask_r, sec_mask_nxt;
  ctl_pkg::word_type step_r, step_nxt;
  ctl_pkg::word_type offset_r [`LOOP_CNT];
  ctl_pkg::word_type offset_nxt [`LOOP_CNT];
  logic wait_r, wait_nxt;
  ctl_pkg::word_type rdata_r, rdata_nxt;
  ctl_pkg::word_type rd_word;
  logic [7:0] out_en_r, out_en_nxt;
  logic [3:0] lock_n_r, lock_n_nxt;
  ctl_pkg::ref_state_type ref_state_r, ref_state_nxt;
  logic [`REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_prev_r;
  logic ref_ok_r, ref_ok_nxt;
  logic req;

  assign req = avs_read | avs_write;

  // Merge write data into a word under the byte enables
  function automatic ctl_pkg::word_type be_merge(
    input ctl_pkg::word_type old_w,
    input ctl_pkg::word_type new_w,
    input logic [3:0] be
  );
    ctl_pkg::word_type res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    case (avs_address)
      `OFS_PRI_MASK: rd_word[7:0] = pri_mask_r;
      `OFS_SEC_MASK: rd_word[7:0] = sec_mask_r;
      `OFS_STEP: rd_word = step_r;
      `OFS_STATUS: begin
        rd_word[`ST_LOCK_LSB +: 4] = lock_n_r;
        rd_word[`ST_REF_OK] = ref_ok_r;
        rd_word[`ST_PRI_PIN] = pri_s;
        rd_word[`ST_SEC_PIN] = sec_s;
        rd_word[`ST_PICK_LSB +: 2] = pick_s;
      end
      `OFS_OFFSET_A: rd_word = offset_r[0];
      `OFS_OFFSET_B: rd_word = offset_r[1];
      `OFS_OFFSET_C: rd_word = offset_r[2];
      `OFS_OFFSET_D: rd_word = offset_r[3];
      default: rd_word = '0;
    endcase
  end

  // Bus handshake: one wait cycle, then the access completes
  always_comb begin
    pri_mask_nxt = pri_mask_r;
    sec_mask_nxt = sec_mask_r;
    step_nxt = step_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (req && wait_r) begin
      // Read data captured now, so it stands when waitrequest drops
      wait_nxt = 1'b0;
      rdata_nxt = rd_word;
    end
    if (avs_write && !wait_r) begin
      case (avs_address)
        `OFS_PRI_MASK: begin
          // Only the low byte is kept; the upper bytes do not exist
          pri_mask_nxt = 8'(be_merge({24'h0, pri_mask_r}, avs_writedata,
                                     avs_byteenable));
        end
        `OFS_SEC_MASK: begin
          sec_mask_nxt = 8'(be_merge({24'h0, sec_mask_r}, avs_writedata,
                                     avs_byteenable));
        end
        `OFS_STEP: begin
          step_nxt = be_merge(step_r, avs_writedata, avs_byteenable);
        end
        // Read-only and unmapped offsets drop writes
        default: begin
        end
      endcase
    end
  end

  // Register the bus state; masks reset to primary-all, secondary-none
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pri_mask_r <= `PRI_MASK_RST;
      sec_mask_r <= `SEC_MASK_RST;
      step_r <= `STEP_RST;
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      pri_mask_r <= pri_mask_nxt;
      sec_mask_r <= sec_mask_nxt;
      step_r <= step_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Output gating: a gate pin high disables the outputs in its mask
  always_comb begin
    // [RL1] Primary gate level
    // [RL2] Primary mask default
    // [RL3] Secondary subset only
    out_en_nxt = ~((pri_mask_r & {8{pri_s}}) | (sec_mask_r & {8{sec_s}}));
  end

  // Lock status follows each loop, low while unlocked
  always_comb begin
    // [RL4] Per loop status
    lock_n_nxt = lock_s;
  end

  // Frequency offset per loop; up and down together cancel
  genvar g;
  generate
    for (g = 0; g < `LOOP_CNT; g++) begin : g_loop
      always_comb begin
        offset_nxt[g] = offset_r[g];
        // [RL6] Select picks loop
        if (pick_s == 2'(g)) begin
          if (step_pulse[1] && !step_pulse[0]) begin
            // [RL8] Raise by step
            offset_nxt[g] = offset_r[g] + step_r;
          end else if (step_pulse[0] && !step_pulse[1]) begin
            // [RL7] Lower by step
            offset_nxt[g] = offset_r[g] - step_r;
          end
        end
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          offset_r[g] <= `OFFSET_RST;
        end else begin
          offset_r[g] <= offset_nxt[g];
        end
      end
    end
  endgenerate

  // Reference monitor: any edge proves activity, a long gap means loss
  always_comb begin
    ref_state_nxt = ref_state_r;
    ref_cnt_nxt = ref_cnt_r;
    case (ref_state_r)
      ctl_pkg::REF_LOST: begin
        ref_cnt_nxt = '0;
        if (ref_s != ref_prev_r) begin
          ref_state_nxt = ctl_pkg::REF_PRESENT;
        end
      end
      ctl_pkg::REF_PRESENT: begin
        // [RL5] Gap means loss
        if (ref_s != ref_prev_r) begin
          ref_cnt_nxt = '0;
        end else if (ref_cnt_r == `REF_CNT_W'(`REF_LOSS_CYC - 1)) begin
          ref_state_nxt = ctl_pkg::REF_LOST;
          ref_cnt_nxt = '0;
        end else begin
          ref_cnt_nxt = ref_cnt_r + `REF_CNT_W'(1);
        end
      end
      default: begin
        ref_state_nxt = ctl_pkg::REF_LOST;
        ref_cnt_nxt = '0;
      end
    endcase
    ref_ok_nxt = (ref_state_nxt == ctl_pkg::REF_PRESENT);
  end

  // Register outputs and monitor; reset shows outputs off, all alarms on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_en_r <= '0;
      lock_n_r <= '0;
      ref_state_r <= ctl_pkg::REF_LOST;
      ref_cnt_r <= '0;
      ref_prev_r <= 1'b0;
      ref_ok_r <= 1'b0;
    end else begin
      out_en_r <= out_en_nxt;
      lock_n_r <= lock_n_nxt;
      ref_state_r <= ref_state_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ref_prev_r <= ref_s;
      ref_ok_r <= ref_ok_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign out_enable = out_en_r;
  assign loop_a_unlocked_n = lock_n_r[0];
  assign loop_b_unlocked_n = lock_n_r[1];
  assign loop_c_unlocked_n = lock_n_r[2];
  assign loop_d_unlocked_n = lock_n_r[3];
  assign ref_signal_missing_n = ref_ok_r;
  assign loop_a_offset = offset_r[0];
  assign loop_b_offset = offset_r[1];
  assign loop_c_offset = offset_r[2];
  assign loop_d_offset = offset_r[3];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // A synchronised step input going low then high
  sequence up_rise_s;
    !step_s[1] ##1 step_s[1];
  endsequence

  // A lone step-up request aimed at loop B
  sequence up_on_b_s;
    step_pulse[1] && !step_pulse[0] && pick_s == 2'h1;
  endsequence

  pri_gate_off_a: assert property ( // [RL1]
    (pri_s && pri_mask_r[0]) |=> !out_enable[0])
    else $error("primary gate high left output 0 on");

  pri_gate_on_a: assert property ( // [RL1]
    (!pri_s && !sec_s) |=> out_enable == 8'hff)
    else $error("both gates low yet an output is off");

  pri_reset_all_a: assert property ( // [RL2]
    (pri_mask_r == `PRI_MASK_RST && pri_s) |=> out_enable == 8'h00)
    else $error("default primary gate missed an output");

  sec_idle_a: assert property ( // [RL3]
    (sec_mask_r == 8'h00 && !pri_s) |=> out_enable == 8'hff)
    else $error("unconfigured secondary gate acted");

  sec_subset_a: assert property ( // [RL3]
    (sec_s && !pri_s) |=> out_enable == ~$past(sec_mask_r))
    else $error("secondary gate hit the wrong outputs");

  lock_follow_a: assert property ( // [RL4]
    ##1 loop_c_unlocked_n == $past(lock_s[2]))
    else $error("loop C status does not follow its lock");

  ref_timeout_a: assert property ( // [RL5]
    (ref_state_r == ctl_pkg::REF_PRESENT && ref_s == ref_prev_r &&
     ref_cnt_r == `REF_CNT_W'(`REF_LOSS_CYC - 1))
    |=> !ref_signal_missing_n)
    else $error("reference gap not flagged");

  step_up_b_a: assert property ( // [RL8]
    up_on_b_s |=> loop_b_offset == $past(offset_r[1]) + $past(step_r))
    else $error("step up did not raise loop B");

  step_sel_only_a: assert property ( // [RL6]
    up_on_b_s |=> $stable(loop_a_offset) && $stable(loop_d_offset))
    else $error("step reached an unselected loop");

  step_down_a: assert property ( // [RL7]
    (step_pulse[0] && !step_pulse[1] && pick_s == 2'h0)
    |=> loop_a_offset == $past(offset_r[0]) - $past(step_r))
    else $error("step down did not lower loop A");

  edge_once_a: assert property ( // [RL9]
    up_rise_s |-> step_pulse[1] ##1 !step_pulse[1])
    else $error("rising edge did not give exactly one request");

endmodule

// File: design/ctl_defs.svh
`ifndef CTL_DEFS_SVH
`define CTL_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_PRI_MASK 8'h00
`define OFS_SEC_MASK 8'h04
`define OFS_STEP 8'h08
`define OFS_STATUS 8'h0c
`define OFS_OFFSET_A 8'h10
`define OFS_OFFSET_B 8'h14
`define OFS_OFFSET_C 8'h18
`define OFS_OFFSET_D 8'h1c

// Reset values
`define PRI_MASK_RST 8'hff
`define SEC_MASK_RST 8'h00
`define STEP_RST 32'h0000_0001
`define OFFSET_RST 32'h0000_0000

// Status register field positions
`define ST_LOCK_LSB 0
`define ST_REF_OK 4
`define ST_PRI_PIN 5
`define ST_SEC_PIN 6
`define ST_PICK_LSB 7

// Sizes
`define OUT_CNT 8
`define LOOP_CNT 4
`define PIN_CNT 11

// Reference loss timing: no edge for this long means the reference is gone
`define CLK_PERIOD_NS 10
`define REF_LOSS_NS 1000
`define REF_LOSS_CYC (`REF_LOSS_NS / `CLK_PERIOD_NS)
`define REF_CNT_W 8

`endif

// File: design/ctl_pkg.sv
package ctl_pkg;

  // Reference monitor states
  typedef enum logic {
    REF_LOST,
    REF_PRESENT
  } ref_state_type;

  // One bus word
  typedef logic [31:0] word_type;

endpackage

// File: design/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage feeds only the second stage
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // Both stages clear to zero, the pulled-down level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// File: design/rise_pulse.sv
`timescale 1ns/1ps
// One-cycle pulse on each rising edge of a synchronised level
module rise_pulse (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic level,
  output logic pulse
);

  // Previous level, cleared so a pin held high out of reset counts once
  logic prev_r;
  logic prev_nxt;

  // Next previous level
  always_comb begin
    prev_nxt = level;
  end

  // Register the level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign pulse = level & ~prev_r;

endmodule

// File: verif/board_model.sv
`timescale 1ns/1ps
// Board controller model: drives the control pins of the block
module board_model (
  input wire logic mclk,
  output logic out_gate_primary_n,
  output logic out_gate_secondary_n,
  output logic loop_pick_bit0,
  output logic loop_pick_bit1,
  output logic freq_step_down,
  output logic freq_step_up,
  output logic ref_crystal_pins,
  output logic [3:0] loop_locked
);
  logic ref_run; // Reference activity on or off

  // Idle levels: secondary gate high to show it is ignored at first
  initial begin
    out_gate_primary_n = 1'b0;
    out_gate_secondary_n = 1'b1;
    {loop_pick_bit1, loop_pick_bit0} = 2'h0;
    freq_step_down = 1'b0;
    freq_step_up = 1'b0;
    ref_crystal_pins = 1'b0;
    loop_locked = 4'h0;
    ref_run = 1'b1;
  end

  // Reference toggles each cycle while running, freezes when stopped
  always @(posedge mclk) begin
    if (ref_run) begin
      ref_crystal_pins <= ~ref_crystal_pins;
    end
  end

  // Gate and lock levels, then time for the sync and output flops
  task automatic set_pins(input logic p, input logic s,
                          input logic [3:0] lk);
    @(posedge mclk);
    out_gate_primary_n <= p;
    out_gate_secondary_n <= s;
    loop_locked <= lk;
    repeat (6) @(posedge mclk);
  endtask

  task automatic step(input logic up, input logic [1:0] pick);
    @(posedge mclk);
    {loop_pick_bit1, loop_pick_bit0} <= pick;
    repeat (3) @(posedge mclk);
    if (up) begin
      freq_step_up <= 1'b1;
    end else begin
      freq_step_down <= 1'b1;
    end
    repeat (3) @(posedge mclk);
    freq_step_up <= 1'b0;
    freq_step_down <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// File: verif/clk_ctl_pins_bench.sv
`timescale 1ns/1ps
`include "ctl_defs.svh"
// Self-checking bench for the pin control block
module clk_ctl_pins_bench;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, out_enable;
  ctl_pkg::word_type avs_writedata, avs_readdata, rd;
  logic pri_n, sec_n, pick0, pick1, down, up, xtal, ref_ok_n;
  logic [3:0] locked, lock_n;
  ctl_pkg::word_type off [4];
  ctl_pkg::word_type exp_off [4];
  int n_errors, checks;

  clk_ctl_pins i_clk_ctl_pins (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .out_gate_primary_n(pri_n),
    .out_gate_secondary_n(sec_n), .loop_pick_bit0(pick0),
    .loop_pick_bit1(pick1), .freq_step_down(down), .freq_step_up(up),
    .ref_crystal_pins(xtal), .loop_locked(locked),
    .out_enable(out_enable), .loop_a_unlocked_n(lock_n[0]),
    .loop_b_unlocked_n(lock_n[1]), .loop_c_unlocked_n(lock_n[2]),
    .loop_d_unlocked_n(lock_n[3]), .ref_signal_missing_n(ref_ok_n),
    .loop_a_offset(off[0]), .loop_b_offset(off[1]),
    .loop_c_offset(off[2]), .loop_d_offset(off[3]));

  board_model i_board_model (.mclk(mclk), .out_gate_primary_n(pri_n),
    .out_gate_secondary_n(sec_n), .loop_pick_bit0(pick0),
    .loop_pick_bit1(pick1), .freq_step_down(down), .freq_step_up(up),
    .ref_crystal_pins(xtal), .loop_locked(locked));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Compare and count; four-state equality so unknowns never match
  task automatic chk(input ctl_pkg::word_type seen,
                     input ctl_pkg::word_type exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low;
  // a slave that never answers is caught by the hang guard
  task automatic bus(input logic wr, input logic [7:0] a,
                     input ctl_pkg::word_type d,
                     output ctl_pkg::word_type q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    n_errors = 0;
    checks = 0;
    for (int i = 0; i < 4; i++) begin
      exp_off[i] = 32'h0;
    end
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values and an unmapped read
    bus(1'b0, `OFS_PRI_MASK, 32'h0, rd);
    chk(rd, 32'h0000_00ff);
    bus(1'b0, `OFS_SEC_MASK, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, `OFS_STEP, 32'h0, rd);
    chk(rd, 32'h1);
    bus(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    // Default gating: secondary high yet all outputs pass
    repeat (4) @(posedge mclk);
    chk(32'(out_enable), 32'h0000_00ff);
    i_board_model.set_pins(1'b1, 1'b1, 4'h0);
    chk(32'(out_enable), 32'h0);
    // Split the outputs between the two gates
    bus(1'b1, `OFS_PRI_MASK, 32'h0000_00f0, rd);
    bus(1'b1, `OFS_SEC_MASK, 32'h0000_000f, rd);
    i_board_model.set_pins(1'b0, 1'b1, 4'h0);
    chk(32'(out_enable), 32'h0000_00f0);
    i_board_model.set_pins(1'b1, 1'b0, 4'h0);
    chk(32'(out_enable), 32'h0000_000f);
    // Each loop on its own lock pin, walking one locked loop
    for (int i = 0; i < 4; i++) begin
      i_board_model.set_pins(1'b0, 1'b0, 4'h1 << i);
      chk(32'(lock_n), 32'(4'h1 << i));
      bus(1'b0, `OFS_STATUS, 32'h0, rd);
      chk(32'(rd[3:0]), 32'(4'h1 << i));
    end
    // Reference present, then frozen past the loss time, then back
    chk(32'(ref_ok_n), 32'h1);
    i_board_model.ref_run <= 1'b0;
    repeat (120) @(posedge mclk);
    chk(32'(ref_ok_n), 32'h0);
    i_board_model.ref_run <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(32'(ref_ok_n), 32'h1);
    // Step up on each loop in turn, others must stay put
    bus(1'b1, `OFS_STEP, 32'h5, rd);
    for (int p = 0; p < 4; p++) begin
      i_board_model.step(1'b1, 2'(p));
      exp_off[p] = exp_off[p] + 32'h5;
      for (int i = 0; i < 4; i++) begin
        chk(off[i], exp_off[i]);
      end
    end
    // One step down on loop A, two on loop C going below zero
    i_board_model.step(1'b0, 2'h0);
    exp_off[0] = exp_off[0] - 32'h5;
    i_board_model.step(1'b0, 2'h2);
    i_board_model.step(1'b0, 2'h2);
    exp_off[2] = exp_off[2] - 32'ha;
    for (int i = 0; i < 4; i++) begin
      chk(off[i], exp_off[i]);
    end
    bus(1'b0, `OFS_OFFSET_C, 32'h0, rd);
    chk(rd, exp_off[2]);
    wrap_up();
  end
endmodule
